// ===== src/ccx_capcmp_top.sv
// two capture/compare/pwm channels, the aux timer they share, and their apb slave
//
// Behaviour
// - aux timer counts up as sixteen bits and wraps from ffff to zero
// - aux overflow latches its flag; interrupt output only when enable bit set
// - channel trigger mode match with aux time base clears the aux count
// - trigger reset from channel two never sets the aux overflow flag
// - software write to aux timer beats a coincident trigger reset
// - secondary oscillator enable bit in first timer control frees the aux source
// - each channel keeps one sixteen bit capture, compare or duty register
// - both channels behave alike except for what their trigger drives
// - channel control bits seven and six read back zero
// - pwm duty is channel low byte above the two control duty bits
// - mode zero turns channel off and resets it; two codes reserved
// - toggle mode flips the pin on match and sets the channel flag
// - capture on falling, rising, fourth rising or sixteenth rising edge
// - set-high mode starts pin low, drives it high on match, sets flag
// - set-low mode starts pin high, drives it low on match, sets flag
// - soft interrupt mode sets only the flag, pin unchanged
// - trigger mode sets the flag and pulses the special event trigger
// - value low byte, high byte and control are each readable and writable
// - capture channels pick first or aux timer through the one shared select field
// - trigger clears whichever timer is the channel time base
// - pwm channels share one pwm time base and update instant
// - select 1x aux for both, 01 aux for two only, 00 first for both
// - internally clocked aux timer steps once every clock
// - capture event copies the chosen time base into the channel value
// - compare checks value against time base and acts on equality
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ccx_capcmp_top import ccx_pkg::*; #(
  parameter int NUM_CH = 2,
  parameter int PWM_W = 10
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // time bases from the first timer and the pwm time base
  input wire logic [15:0] FIRST_TIMER_COUNT,
  input wire logic [PWM_W-1:0] PWM_TIMEBASE_COUNT,
  input wire logic PWM_PERIOD_MATCH,
  input wire logic EXT_CLK_IN,
  // channel pins
  input wire logic [NUM_CH-1:0] CH_PIN_IN,
  output logic [NUM_CH-1:0] CH_PIN_OUT,
  // events to the rest of the chip
  output logic FIRST_TIMER_CLEAR,
  output logic ADC_START,
  output logic SEC_OSC_ENABLE,
  output logic AUX_OVF_IRQ,
  output logic [NUM_CH-1:0] CH_FLAG
);
  // register state
  logic [3:0] flags_two_ff;
  logic [3:0] enables_two_ff;
  logic [3:0] priority_two_ff;
  logic [15:0] aux_count_ff;
  logic [7:0] aux_ctrl_ff;
  logic [5:0] first_ctrl_ff;
  logic ch_one_flag_ff;
  logic ext_q_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  // per channel state
  logic [5:0] ch_ctrl_ff [NUM_CH];
  logic [15:0] ch_val_ff [NUM_CH];
  logic [PWM_W-1:0] duty_ff [NUM_CH];
  logic [3:0] psc_ff [NUM_CH];
  logic [NUM_CH-1:0] pin_ff;
  logic [NUM_CH-1:0] match_q_ff;
  logic [NUM_CH-1:0] in_q_ff;
  // per channel combinational
  logic [NUM_CH-1:0] use_aux;
  logic [NUM_CH-1:0] trig;
  logic [NUM_CH-1:0] flag_set;
  logic [NUM_CH-1:0] cap_evt;
  logic [NUM_CH-1:0] match_rise;
  logic [15:0] tb [NUM_CH];
  logic [NUM_CH-1:0] wr_ctrl;
  logic [NUM_CH-1:0] wr_low;
  logic [NUM_CH-1:0] wr_high;
  // bus strobes
  logic wr_en;
  logic rd_setup;
  logic wr_aux_low;
  logic wr_aux_high;
  logic aux_inc;
  logic aux_trig;
  logic aux_wrap;

  // zero wait state slave: read data is latched in the setup cycle
  assign PREADY = 1'b1;
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE;
  assign PRDATA = prdata_ff;
  assign PSLVERR = pslverr_ff;
  assign wr_aux_low = wr_en && PADDR == OFS_AUX_LOW;
  assign wr_aux_high = wr_en && PADDR == OFS_AUX_HIGH;

  // read mux; unmapped addresses answer zero with an error
  always_comb begin
    nxt_rdata = RD_ZERO;
    nxt_err = 1'b0;
    case (PADDR)
      OFS_FLAGS_TWO: nxt_rdata[3:0] = flags_two_ff;
      OFS_ENABLES_TWO: nxt_rdata[3:0] = enables_two_ff;
      OFS_PRIORITY_TWO: nxt_rdata[3:0] = priority_two_ff;
      OFS_AUX_LOW: nxt_rdata[7:0] = aux_count_ff[7:0];
      OFS_AUX_HIGH: nxt_rdata[7:0] = aux_count_ff[15:8];
      OFS_AUX_CTRL: nxt_rdata[7:0] = aux_ctrl_ff;
      OFS_FIRST_CTRL: nxt_rdata[5:0] = first_ctrl_ff;
      OFS_CH_ONE_FLAG: nxt_rdata[0] = ch_one_flag_ff;
      default: nxt_err = 1'b1;
    endcase
    for (int i = 0; i < NUM_CH; i++) begin
      if (PADDR == 8'(OFS_CH_BASE + OFS_CH_STRIDE * i)) begin
        nxt_rdata[5:0] = ch_ctrl_ff[i]; // bits 7:6 stay zero
        nxt_err = 1'b0;
      end
      if (PADDR == 8'(OFS_CH_BASE + OFS_CH_STRIDE * i + OFS_CH_LOW)) begin
        nxt_rdata[7:0] = ch_val_ff[i][7:0];
        nxt_err = 1'b0;
      end
      if (PADDR == 8'(OFS_CH_BASE + OFS_CH_STRIDE * i + OFS_CH_HIGH)) begin
        nxt_rdata[7:0] = ch_val_ff[i][15:8];
        nxt_err = 1'b0;
      end
    end
  end

  // read data and error register
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prdata_ff <= RD_ZERO;
      pslverr_ff <= 1'b0;
    end else if (rd_setup) begin
      prdata_ff <= PWRITE ? RD_ZERO : nxt_rdata;
      pslverr_ff <= nxt_err;
    end
  end

  // plain configuration registers
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      enables_two_ff <= 4'h0;
      priority_two_ff <= 4'h0;
      aux_ctrl_ff <= RST_BYTE;
      first_ctrl_ff <= 6'h00;
    end else if (wr_en) begin
      if (PADDR == OFS_ENABLES_TWO) enables_two_ff <= PWDATA[3:0];
      if (PADDR == OFS_PRIORITY_TWO) priority_two_ff <= PWDATA[3:0];
      if (PADDR == OFS_AUX_CTRL) aux_ctrl_ff <= PWDATA[7:0];
      if (PADDR == OFS_FIRST_CTRL) first_ctrl_ff <= PWDATA[5:0] & FIRST_CTRL_MASK;
    end
  end

  // oscillator enable leaves the block so the pad logic can start it
  assign SEC_OSC_ENABLE = first_ctrl_ff[BIT_OSC_EN];

  // external source edge; the input is already synchronous to the core clock
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) ext_q_ff <= 1'b0;
    else ext_q_ff <= EXT_CLK_IN;
  end

  // increment: every clock when internal, on rising edge of the external source
  assign aux_inc = aux_ctrl_ff[BIT_AUX_ON] &
    (aux_ctrl_ff[BIT_AUX_SRC] ? (EXT_CLK_IN & ~ext_q_ff) : 1'b1);
  assign aux_trig = |(trig & use_aux);
  assign aux_wrap = aux_inc && !aux_trig && aux_count_ff == AUX_MAX &&
    !wr_aux_low && !wr_aux_high;

  // aux counter: software write beats trigger reset, reset beats increment
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aux_count_ff <= RST_WORD;
    end else if (wr_aux_low || wr_aux_high) begin
      if (wr_aux_low) aux_count_ff[7:0] <= PWDATA[7:0];
      if (wr_aux_high) aux_count_ff[15:8] <= PWDATA[7:0];
    end else if (aux_trig) begin
      aux_count_ff <= RST_WORD;
    end else if (aux_inc) begin
      aux_count_ff <= aux_count_ff + 16'h0001; // wraps ffff to 0000
    end
  end

  // flag register two: hardware set wins over a software write in the same cycle
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      flags_two_ff <= 4'h0;
    end else begin
      if (wr_en && PADDR == OFS_FLAGS_TWO) flags_two_ff <= PWDATA[3:0] & FLAGS_TWO_MASK;
      if (aux_wrap) flags_two_ff[BIT_AUX_OVF] <= 1'b1; // only a true wrap
      if (flag_set[1]) flags_two_ff[BIT_CH_TWO_FLAG] <= 1'b1;
    end
  end

  // channel one flag lives in its own register
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) ch_one_flag_ff <= 1'b0;
    else if (flag_set[0]) ch_one_flag_ff <= 1'b1;
    else if (wr_en && PADDR == OFS_CH_ONE_FLAG) ch_one_flag_ff <= PWDATA[0];
  end

  assign AUX_OVF_IRQ = flags_two_ff[BIT_AUX_OVF] & enables_two_ff[BIT_AUX_OVF];
  assign CH_FLAG = {flags_two_ff[BIT_CH_TWO_FLAG], ch_one_flag_ff};

  // time base routing: aux for both, aux for two only, or first for both
  assign use_aux[0] = aux_ctrl_ff[BIT_TBSEL_HI];
  assign use_aux[1] = aux_ctrl_ff[BIT_TBSEL_HI] | aux_ctrl_ff[BIT_TBSEL_LO];

  // trigger targets: first timer clear from any channel on the first timer, conversion start from two
  assign FIRST_TIMER_CLEAR = |(trig & ~use_aux);
  assign ADC_START = trig[1];
  assign CH_PIN_OUT = pin_ff;

  // identical channel slices; only where the trigger goes differs
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic [3:0] mode;
    logic [3:0] nmode;
    logic rise;
    logic fall;
    logic match;
    ccx_kind_type kind;
    assign mode = ch_ctrl_ff[g][3:0];
    assign nmode = PWDATA[3:0];
    assign tb[g] = use_aux[g] ? aux_count_ff : FIRST_TIMER_COUNT;
    assign wr_ctrl[g] = wr_en && PADDR == 8'(OFS_CH_BASE + OFS_CH_STRIDE * g);
    assign wr_low[g] = wr_en && PADDR == 8'(OFS_CH_BASE + OFS_CH_STRIDE * g + OFS_CH_LOW);
    assign wr_high[g] = wr_en && PADDR == 8'(OFS_CH_BASE + OFS_CH_STRIDE * g + OFS_CH_HIGH);
    assign rise = CH_PIN_IN[g] & ~in_q_ff[g];
    assign fall = ~CH_PIN_IN[g] & in_q_ff[g];

    // mode decode; reserved codes behave as off
    always_comb begin
      case (mode[3:2])
        MODE_PWM_TOP: kind = CK_PWM;
        MODE_CAP_TOP: kind = CK_CAPTURE;
        default: kind = (mode == MODE_OFF || mode == MODE_RSV_A ||
          mode == MODE_RSV_B) ? CK_OFF : CK_COMPARE;
      endcase
    end

    // equality is acted on once, at the cycle the timer reaches the value
    assign match = kind == CK_COMPARE && ch_val_ff[g] == tb[g];
    assign match_rise[g] = match & ~match_q_ff[g];
    assign trig[g] = match_rise[g] && mode == MODE_TRIGGER;

    // capture event with prescaler count
    always_comb begin
      case (mode)
        MODE_CAP_FALL: cap_evt[g] = fall;
        MODE_CAP_RISE: cap_evt[g] = rise;
        MODE_CAP_4TH: cap_evt[g] = rise && psc_ff[g] == PSC_FOURTH;
        MODE_CAP_16TH: cap_evt[g] = rise && psc_ff[g] == PSC_SIXTEENTH;
        default: cap_evt[g] = 1'b0;
      endcase
    end
    assign flag_set[g] = cap_evt[g] | match_rise[g];

    // edge history, match history and prescaler; only the prescaler clears outside capture
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        in_q_ff[g] <= 1'b0;
        match_q_ff[g] <= 1'b0;
        psc_ff[g] <= 4'h0;
      end else begin
        in_q_ff[g] <= CH_PIN_IN[g];
        match_q_ff[g] <= match;
        if (kind != CK_CAPTURE) psc_ff[g] <= 4'h0;
        else if (cap_evt[g] && mode != MODE_CAP_FALL) psc_ff[g] <= 4'h0;
        else if (rise) psc_ff[g] <= psc_ff[g] + PSC_ONE;
      end
    end

    // control register, bits 5:0 only
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) ch_ctrl_ff[g] <= 6'h00;
      else if (wr_ctrl[g]) ch_ctrl_ff[g] <= PWDATA[5:0] & CH_CTRL_MASK;
    end

    // value register: one 16-bit store for capture, compare and duty
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        ch_val_ff[g] <= RST_WORD;
      end else if (wr_low[g] || wr_high[g]) begin
        if (wr_low[g]) ch_val_ff[g][7:0] <= PWDATA[7:0];
        if (wr_high[g]) ch_val_ff[g][15:8] <= PWDATA[7:0];
      end else if (cap_evt[g]) begin
        ch_val_ff[g] <= tb[g]; // unread old capture is overwritten
      end else if (kind == CK_PWM && PWM_PERIOD_MATCH) begin
        ch_val_ff[g][15:8] <= ch_val_ff[g][7:0]; // duty copy visible to software
      end
    end

    // duty latched at the shared period instant so both channels update together
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) duty_ff[g] <= '0;
      else if (kind == CK_PWM && PWM_PERIOD_MATCH)
        duty_ff[g] <= {ch_val_ff[g][7:0], ch_ctrl_ff[g][5:4]};
    end

    // pin latch: set by mode write, then moved by compare or pwm
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        pin_ff[g] <= 1'b0;
      end else if (wr_ctrl[g] && nmode == MODE_OFF) begin
        pin_ff[g] <= 1'b0; // off forces the output latch low
      end else if (wr_ctrl[g] && nmode == MODE_SET_HIGH) begin
        pin_ff[g] <= 1'b0;
      end else if (wr_ctrl[g] && nmode == MODE_SET_LOW) begin
        pin_ff[g] <= 1'b1;
      end else if (kind == CK_PWM) begin
        // a duty of zero never raises the pin
        if (PWM_PERIOD_MATCH) pin_ff[g] <= |{ch_val_ff[g][7:0], ch_ctrl_ff[g][5:4]};
        else if (PWM_TIMEBASE_COUNT == duty_ff[g]) pin_ff[g] <= 1'b0;
      end else if (match_rise[g]) begin
        case (mode)
          MODE_TOGGLE: pin_ff[g] <= ~pin_ff[g];
          MODE_SET_HIGH: pin_ff[g] <= 1'b1;
          MODE_SET_LOW: pin_ff[g] <= 1'b0;
          default: pin_ff[g] <= pin_ff[g]; // soft irq and trigger leave it
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_no_aux_write;
    !wr_aux_low && !wr_aux_high;
  endsequence
  sequence s_aux_at_max;
    aux_inc && !aux_trig && aux_count_ff == AUX_MAX;
  endsequence

  aux_wrap_flag_a: assert property (s_aux_at_max and s_no_aux_write
    |=> aux_count_ff == RST_WORD && flags_two_ff[BIT_AUX_OVF])
    else $error("aux timer did not wrap to zero with flag");
  aux_step_a: assert property (aux_inc && !aux_trig && !wr_aux_low && !wr_aux_high
    |=> aux_count_ff == $past(aux_count_ff) + 16'h0001)
    else $error("aux timer did not step by one");
  ovf_irq_a: assert property ($rose(flags_two_ff[BIT_AUX_OVF]) &&
    enables_two_ff[BIT_AUX_OVF] |-> AUX_OVF_IRQ)
    else $error("enabled overflow gave no interrupt");
  trig_reset_a: assert property (aux_trig && !wr_aux_low && !wr_aux_high
    |=> aux_count_ff == RST_WORD)
    else $error("trigger did not clear aux timer");
  trig_noflag_a: assert property (trig[1] && use_aux[1] && !flags_two_ff[BIT_AUX_OVF]
    |=> !flags_two_ff[BIT_AUX_OVF])
    else $error("channel two trigger set overflow flag");
  write_wins_a: assert property (aux_trig && wr_aux_low && !wr_aux_high
    |=> aux_count_ff[7:0] == $past(PWDATA[7:0]) &&
      aux_count_ff[15:8] == $past(aux_count_ff[15:8]))
    else $error("trigger reset beat software write");
  ctrl_top_zero_a: assert property (rd_setup && !PWRITE &&
    PADDR == OFS_CH_BASE |=> PRDATA[7:6] == 2'h0 && PRDATA[5:0] == $past(ch_ctrl_ff[0]))
    else $error("channel control read wrong");
  capture_copy_a: assert property (cap_evt[0] && !wr_low[0] && !wr_high[0]
    |=> ch_val_ff[0] == $past(tb[0]) && ch_one_flag_ff)
    else $error("capture did not copy time base");
  toggle_pin_a: assert property (match_rise[0] && ch_ctrl_ff[0][3:0] == MODE_TOGGLE &&
    !wr_ctrl[0] |=> CH_PIN_OUT[0] == !$past(CH_PIN_OUT[0]) && CH_FLAG[0])
    else $error("toggle mode did not flip the pin");
  first_clear_a: assert property (ch_ctrl_ff[0][3:0] == MODE_TRIGGER && !use_aux[0] &&
    ch_val_ff[0] == FIRST_TIMER_COUNT && !match_q_ff[0] |-> FIRST_TIMER_CLEAR)
    else $error("trigger did not clear first timer");
endmodule

// ===== src/ccx_pkg.sv
// constants, offsets and mode codes for the capture/compare block with aux timer
package ccx_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_FLAGS_TWO = 8'h00;
  localparam logic [7:0] OFS_ENABLES_TWO = 8'h04;
  localparam logic [7:0] OFS_PRIORITY_TWO = 8'h08;
  localparam logic [7:0] OFS_AUX_LOW = 8'h0c;
  localparam logic [7:0] OFS_AUX_HIGH = 8'h10;
  localparam logic [7:0] OFS_AUX_CTRL = 8'h14;
  localparam logic [7:0] OFS_FIRST_CTRL = 8'h18;
  localparam logic [7:0] OFS_CH_BASE = 8'h1c;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h0c;
  localparam logic [7:0] OFS_CH_LOW = 8'h04;
  localparam logic [7:0] OFS_CH_HIGH = 8'h08;
  localparam logic [7:0] OFS_CH_ONE_FLAG = 8'h34;
  // field positions
  localparam int BIT_AUX_OVF = 1;
  localparam int BIT_CH_TWO_FLAG = 0;
  localparam int BIT_RD16 = 7;
  localparam int BIT_TBSEL_HI = 6;
  localparam int BIT_TBSEL_LO = 3;
  localparam int BIT_AUX_SRC = 1;
  localparam int BIT_AUX_ON = 0;
  localparam int BIT_OSC_EN = 3;
  // reset values and widths
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] AUX_MAX = 16'hffff;
  localparam logic [3:0] FLAGS_TWO_MASK = 4'hf;
  localparam logic [5:0] FIRST_CTRL_MASK = 6'h3f;
  localparam logic [5:0] CH_CTRL_MASK = 6'h3f;
  localparam logic [3:0] PSC_FOURTH = 4'h3;
  localparam logic [3:0] PSC_SIXTEENTH = 4'hf;
  localparam logic [3:0] PSC_ONE = 4'h1;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // channel mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_RSV_A = 4'h1;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_RSV_B = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4TH = 4'h6;
  localparam logic [3:0] MODE_CAP_16TH = 4'h7;
  localparam logic [3:0] MODE_SET_HIGH = 4'h8;
  localparam logic [3:0] MODE_SET_LOW = 4'h9;
  localparam logic [3:0] MODE_SOFT_IRQ = 4'ha;
  localparam logic [3:0] MODE_TRIGGER = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [1:0] MODE_CAP_TOP = 2'h1;
  // channel kind decoded from the mode field
  typedef enum {CK_OFF, CK_CAPTURE, CK_COMPARE, CK_PWM} ccx_kind_type;
endpackage

// ===== tb/ccx_pin_partner.sv
// far-side model: first timer, pwm time base and capture pin drivers
`timescale 1ns/1ps
module ccx_pin_partner (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench requests and block events
  input wire logic hold,
  input wire logic [1:0] drv,
  input wire logic first_clear,
  // towards the block
  output logic [15:0] first_count,
  output logic [9:0] pwm_count,
  output logic pwm_match,
  output logic [1:0] pin_in
);
  // first timer wraps at 256 so compare matches come around quickly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) first_count <= 16'h0000;
    else if (first_clear) first_count <= 16'h0000; // trigger clears its time base
    else if (!hold) first_count <= {8'h00, first_count[7:0] + 8'h01};
  end
  // pwm time base wraps from 63 to 0, a period of 64 cycles, and marks the period end for one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pwm_count <= 10'h000;
    else pwm_count <= (pwm_count == 10'h03f) ? 10'h000 : pwm_count + 10'h001;
  end
  assign pwm_match = (pwm_count == 10'h03f);
  // pins change just after an edge, like a synchronous source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pin_in <= 2'h0;
    else pin_in <= drv;
  end
endmodule

// ===== tb/tb_capcmp_control_with_aux_timer.sv
// self-checking bench: apb tasks, scenarios and verdict
`timescale 1ns/1ps
module tb_capcmp_control_with_aux_timer import ccx_pkg::*; ;
  logic clk, rst_n, psel, pen, pwr, hold, e, seen_ft, seen_adc, ext;
  logic [7:0] paddr;
  logic [31:0] pwdata, q;
  logic [1:0] drv;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, ft_clr, adc, osc, irq, pwm_m;
  wire logic [15:0] ft;
  wire logic [9:0] pwm_c;
  wire logic [1:0] pin_in, pin_out, flag;
  int miscompares, samples_checked, cycles;
  localparam logic [7:0] CH2 = OFS_CH_BASE + OFS_CH_STRIDE;

  ccx_capcmp_top ccx_capcmp_top_inst (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FIRST_TIMER_COUNT(ft), .PWM_TIMEBASE_COUNT(pwm_c),
    .PWM_PERIOD_MATCH(pwm_m), .EXT_CLK_IN(ext), .CH_PIN_IN(pin_in), .CH_PIN_OUT(pin_out),
    .FIRST_TIMER_CLEAR(ft_clr), .ADC_START(adc), .SEC_OSC_ENABLE(osc), .AUX_OVF_IRQ(irq),
    .CH_FLAG(flag));
  ccx_pin_partner ccx_pin_partner_inst (.clk(clk), .rst_n(rst_n), .hold(hold), .drv(drv),
    .first_clear(ft_clr), .first_count(ft), .pwm_count(pwm_c), .pwm_match(pwm_m),
    .pin_in(pin_in));

  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // sticky event catchers and the hang limit
  always @(posedge clk) begin
    if (ft_clr) seen_ft <= 1'b1;
    if (adc) seen_adc <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the access phase lasts until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    while (flag[b] !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(flag[b], 1'b1);
  endtask
  // capture source pulse on both pins; long enough for sync and flag update
  task automatic pulse;
    @(posedge clk);
    drv <= 2'h3;
    repeat (4) @(posedge clk);
    drv <= 2'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_regs;
    rd(OFS_FLAGS_TWO, 32'h0);
    rd(OFS_AUX_CTRL, 32'h0);
    wr(OFS_CH_BASE, 32'hff);
    rd(OFS_CH_BASE, 32'h3f);
    wr(OFS_CH_BASE + OFS_CH_HIGH, 32'ha5);
    rd(OFS_CH_BASE + OFS_CH_HIGH, 32'ha5);
    wr(OFS_CH_BASE, 32'h0);
    rd(8'h3c, 32'h0);
    chk(e, 1'b1);
    wr(OFS_FIRST_CTRL, 32'h08);
    chk(osc, 1'b1);
    $display("test regs done");
  endtask

  // every compare mode on channel one, first timer as time base
  task automatic t_compare;
    logic [3:0] m [5] = '{MODE_TOGGLE, MODE_SET_HIGH, MODE_SET_LOW, MODE_SOFT_IRQ,
      MODE_TRIGGER};
    logic [4:0] i0 = 5'h04;
    logic [4:0] i1 = 5'h03;
    wr(OFS_AUX_CTRL, 32'h0);
    wr(OFS_CH_BASE + OFS_CH_LOW, 32'h40);
    wr(OFS_CH_BASE + OFS_CH_HIGH, 32'h0); // high byte left over from the register test
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CH_BASE, 32'h0);
      chk(pin_out[0], 1'b0);
      wr(OFS_CH_ONE_FLAG, 32'h0);
      wr(OFS_CH_BASE, m[i]);
      chk(pin_out[0], i0[i]);
      seen_ft = 1'b0;
      wait_flag(0);
      chk(pin_out[0], i1[i]);
      chk(seen_ft, i == 4);
    end
    wr(OFS_CH_BASE, 32'h0);
    $display("test compare done");
  endtask

  task automatic t_aux;
    wr(OFS_FLAGS_TWO, 32'h0);
    wr(OFS_AUX_LOW, 32'hf0);
    wr(OFS_AUX_HIGH, 32'hff);
    wr(OFS_AUX_CTRL, 32'h01); // on with the internal clock, one step every clock
    repeat (40) @(posedge clk);
    rd(OFS_AUX_LOW, 32'h19);
    rd(OFS_AUX_HIGH, 32'h0);
    rd(OFS_FLAGS_TWO, 32'h2);
    chk(irq, 1'b0);
    wr(OFS_ENABLES_TWO, 32'h2);
    chk(irq, 1'b1);
    wr(OFS_FLAGS_TWO, 32'h0);
    chk(irq, 1'b0);
    // external source: one step per rising edge of the source input
    wr(OFS_AUX_CTRL, 32'h03);
    wr(OFS_AUX_LOW, 32'h0);
    wr(OFS_AUX_HIGH, 32'h0);
    repeat (3) begin
      @(posedge clk);
      ext <= 1'b1;
      @(posedge clk);
      ext <= 1'b0;
    end
    rd(OFS_AUX_LOW, 32'h3);
    $display("test aux done");
  endtask

  // channel two trigger on the aux timer makes it a period register
  task automatic t_trigger;
    wr(OFS_AUX_CTRL, 32'h0);
    wr(OFS_AUX_LOW, 32'h0);
    wr(OFS_AUX_HIGH, 32'h0);
    wr(CH2 + OFS_CH_LOW, 32'h20);
    wr(OFS_AUX_CTRL, 32'h09);
    wr(OFS_FLAGS_TWO, 32'h0);
    seen_adc = 1'b0;
    seen_ft = 1'b0;
    wr(CH2, MODE_TRIGGER);
    wait_flag(1);
    repeat (300) @(posedge clk);
    chk(seen_adc, 1'b1);
    chk(seen_ft, 1'b0);
    apb(1'b0, OFS_AUX_LOW, 32'h0);
    chk(q <= 32'h20, 1'b1);
    rd(OFS_FLAGS_TWO, 32'h1);
    // second write lands on the edge where the trigger reset would clear the count
    wr(OFS_AUX_LOW, 32'h1e);
    wr(OFS_AUX_LOW, 32'h05);
    rd(OFS_AUX_LOW, 32'h06);
    wr(CH2, 32'h0);
    wr(OFS_AUX_CTRL, 32'h0);
    $display("test trigger done");
  endtask

  // all capture edge choices with a frozen first timer
  task automatic t_capture;
    logic [3:0] m [4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_4TH, MODE_CAP_16TH};
    int n [4] = '{1, 1, 4, 16};
    hold <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CH_BASE, 32'h0);
      wr(OFS_CH_ONE_FLAG, 32'h0);
      wr(OFS_CH_BASE, m[i]);
      for (int k = 1; k < n[i]; k++) pulse();
      chk(flag[0], 1'b0);
      pulse();
      chk(flag[0], 1'b1);
      rd(OFS_CH_BASE + OFS_CH_LOW, ft[7:0]);
      rd(OFS_CH_BASE + OFS_CH_HIGH, ft[15:8]);
    end
    wr(OFS_CH_BASE, 32'h0);
    hold <= 1'b0;
    $display("test capture done");
  endtask

  // duty 5 on channel one, 32 on channel two, one shared period
  task automatic t_pwm;
    int h0, h1;
    h0 = 0;
    h1 = 0;
    wr(OFS_CH_BASE + OFS_CH_LOW, 32'h01);
    wr(OFS_CH_BASE, 32'h1c);
    wr(CH2 + OFS_CH_LOW, 32'h08);
    wr(CH2, 32'h0c);
    repeat (128) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      #1;
      h0 += pin_out[0];
      h1 += pin_out[1];
    end
    chk(h1 - h0, 32'd27);
    chk(h0 > 4 && h0 < 7, 1'b1);
    $display("test pwm done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // reset for five cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    {psel, pen, pwr, hold, ext} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    drv = 2'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_compare();
    t_aux();
    t_trigger();
    t_capture();
    t_pwm();
    tally_and_finish();
  end
endmodule
